// ==== shared/mbp_pkg.sv ====
// Purpose: Shared constants and carrier types for the microcode breakpoint panel.
// Assumes: 16-bit microaddress bus, 32-bit store output lamp row.
// Notes:   Field positions and reset values are named here once.
package mbp_pkg;

  localparam int ADDR_W        = 16;
  localparam int LAMP_W        = 32;
  localparam int RANK1_LO_HI   = 4;
  localparam int RANK1_HI_LO   = 28;
  localparam int RANK2_LO      = 5;
  localparam int RANK2_HI      = 27;
  localparam int JUMP_LSB      = 2;
  localparam int DISP_W        = 16;
  localparam int SYNC_STAGES   = 2;
  localparam logic RST_HALT    = 1'b0;
  localparam logic RST_FRZ     = 1'b0;

  typedef enum logic [1:0] {
    MBP_RUN    = 2'b00,
    MBP_HALTED = 2'b01,
    MBP_JFRZ   = 2'b10
  } mbp_run_t;

  typedef struct packed {
    logic       cmpEnable;
    logic       haltNotJump;
    logic [1:0] bankSw;
    logic       dispSelBus;
  } mbp_switch_t;

  typedef struct packed {
    logic       doJump;
    logic [ADDR_W-1:0] jumpAddr;
    logic       freeze;
    logic       trigger;
  } mbp_seq_t;

endpackage

// ==== src/mbp_button_sync.sv ====
// Purpose: Synchronise a spring-return button and emit a one-cycle press pulse.
// Assumes: Button is a level from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module mbp_button_sync
  import mbp_pkg::*;
(
  input  wire logic clk_sys,  // Processor clock.
  input  wire logic reset,    // Synchronous reset, active high.
  input  wire logic button,   // Raw button level.
  output logic      press     // One-cycle pulse per press.
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mbp_bsync_t;

  mbp_bsync_t st_r;
  mbp_bsync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = button;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign press = st_r.s2 & ~st_r.s3;

  a_press_single : assert property (@(posedge clk_sys) disable iff (reset)
    press |=> !press)
    else $error("press pulse lasted more than one cycle");
endmodule

// ==== src/mbp_panel.sv ====
// Purpose: Maintenance panel breakpoint, jump, restart and display logic.
// Assumes: Microaddress bus and store ranks are on the processor clock.
// Notes:   Switch levels and buttons are synchronised before use.
`timescale 1ns/1ps
module mbp_panel
  import mbp_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic              clk_sys,        // Processor clock.
  input  wire logic              reset,          // Synchronous reset.
  input  wire logic [AW-1:0]     microAddr,      // Microaddress bus.
  input  wire logic [LAMP_W-1:0] firstRankOut,   // First-rank store output.
  input  wire logic [LAMP_W-1:0] secondRankOut,  // Second-rank store output.
  input  wire logic [1:0]        bankBits,       // Current bank bits.
  input  wire logic              specialFreeze,  // Special-field freeze code decoded.
  input  wire logic [DISP_W-1:0] selRegValue,    // Register picked by selection lamp.
  input  wire logic [DISP_W-1:0] resultBus,      // Micro-result bus.
  input  wire logic [AW-1:0]     compareSw,      // Compare switches 0 to 15.
  input  wire logic [AW-1:0]     jumpSw,         // Jump switches, bits 2 to 15 used.
  input  wire logic              cmpEnableSw,    // Compare enable switch.
  input  wire logic              haltSelSw,      // High selects halt, low jump.
  input  wire logic [1:0]        bankSw,         // Bank bit switches.
  input  wire logic              dispBusSw,      // High selects bus display.
  input  wire logic              jumpButton,     // Manual jump button.
  input  wire logic              restartButton,  // Restart button.
  output logic [LAMP_W-1:0]      storeLamps,     // Store output lamps.
  output logic [1:0]             bankLamps,      // Bank bit lamps.
  output logic [AW-1:JUMP_LSB]   addrLamps,      // Microaddress lamps.
  output logic [DISP_W-1:0]      regDispLamps,   // Register display lamps.
  output logic                   freezeLamp,     // Panel freeze lamp.
  output logic                   addressMatchPulse, // Trigger pulse.
  output logic [1:0]             bankSelect,     // Bank bits to store addressing.
  output logic                   seqFreeze,      // Freeze the microsequencer.
  output logic                   seqLoad,        // Load new microaddress.
  output logic [AW-1:0]          seqLoadAddr     // Address to load.
);

  typedef struct packed {
    mbp_switch_t       sw1;
    mbp_switch_t       sw2;
    logic [AW-1:0]     cmp1;
    logic [AW-1:0]     cmp2;
    logic [AW-1:0]     jmp1;
    logic [AW-1:0]     jmp2;
    mbp_run_t          run;
    logic              specFrz;
    logic              trig;
    logic              load;
    logic [AW-1:0]     loadAddr;
    logic [LAMP_W-1:0] lamps;
    logic [1:0]        bankL;
    logic [AW-1:JUMP_LSB] addrL;
    logic [DISP_W-1:0] dispL;
    logic              frzL;
  } mbp_state_t;

  mbp_state_t  st_r;
  mbp_state_t  st_nxt;
  logic        jumpPress;
  logic        restartPress;
  logic        match;
  logic [AW-1:0] jumpTarget;

  mbp_button_sync u_jump (
    .clk_sys (clk_sys),
    .reset   (reset),
    .button  (jumpButton),
    .press   (jumpPress)
  );

  mbp_button_sync u_restart (
    .clk_sys (clk_sys),
    .reset   (reset),
    .button  (restartButton),
    .press   (restartPress)
  );

  assign match      = (microAddr == st_r.cmp2);
  assign jumpTarget = {st_r.jmp2[AW-1:JUMP_LSB], {JUMP_LSB{1'b0}}};

  always_comb begin
    st_nxt              = st_r;
    st_nxt.sw1.cmpEnable   = cmpEnableSw;
    st_nxt.sw1.haltNotJump = haltSelSw;
    st_nxt.sw1.bankSw      = bankSw;
    st_nxt.sw1.dispSelBus  = dispBusSw;
    st_nxt.sw2          = st_r.sw1;
    st_nxt.cmp1         = compareSw;
    st_nxt.cmp2         = st_r.cmp1;
    st_nxt.jmp1         = jumpSw;
    st_nxt.jmp2         = st_r.jmp1;
    st_nxt.trig         = match;
    st_nxt.load         = 1'b0;
    st_nxt.loadAddr     = st_r.loadAddr;
    case (st_r.run)
      MBP_RUN: begin
        if (jumpPress) begin
          st_nxt.load     = 1'b1;
          st_nxt.loadAddr = jumpTarget;
          st_nxt.run      = MBP_JFRZ;
        end else if (match && st_r.sw2.cmpEnable) begin
          if (st_r.sw2.haltNotJump) begin
            st_nxt.run = MBP_HALTED;
          end else begin
            st_nxt.load     = 1'b1;
            st_nxt.loadAddr = jumpTarget;
            st_nxt.run      = MBP_JFRZ;
          end
        end
      end
      MBP_HALTED: begin
        if (restartPress) begin
          st_nxt.run = MBP_RUN;
        end else if (jumpPress) begin
          st_nxt.load     = 1'b1;
          st_nxt.loadAddr = jumpTarget;
          st_nxt.run      = MBP_HALTED;
        end
      end
      MBP_JFRZ: begin
        st_nxt.run = MBP_RUN;
      end
      default: begin
        st_nxt.run = MBP_RUN;
      end
    endcase
    if (restartPress) begin
      st_nxt.specFrz = 1'b0;
    end
    if (specialFreeze) begin
      st_nxt.specFrz = 1'b1;
    end
    st_nxt.lamps = firstRankOut;
    st_nxt.lamps[RANK2_HI:RANK2_LO] = secondRankOut[RANK2_HI:RANK2_LO];
    st_nxt.bankL = bankBits;
    st_nxt.addrL = microAddr[AW-1:JUMP_LSB];
    st_nxt.dispL = st_r.sw2.dispSelBus ? resultBus : selRegValue;
    st_nxt.frzL  = (st_nxt.run == MBP_HALTED) || match;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r         <= '0;
      st_r.run     <= MBP_RUN;
      st_r.specFrz <= RST_FRZ;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign storeLamps        = st_r.lamps;
  assign bankLamps         = st_r.bankL;
  assign addrLamps         = st_r.addrL;
  assign regDispLamps      = st_r.dispL;
  assign freezeLamp        = st_r.frzL;
  assign addressMatchPulse = st_r.trig;
  assign bankSelect        = st_r.sw2.bankSw;
  assign seqLoad           = st_r.load;
  assign seqLoadAddr       = st_r.loadAddr;
  assign seqFreeze         = (st_r.run != MBP_RUN) || st_r.specFrz;

  sequence s_enabledHaltMatch;
    (st_r.run == MBP_RUN) && match && st_r.sw2.cmpEnable && st_r.sw2.haltNotJump && !jumpPress;
  endsequence

  sequence s_enabledJumpMatch;
    (st_r.run == MBP_RUN) && match && st_r.sw2.cmpEnable && !st_r.sw2.haltNotJump && !jumpPress;
  endsequence

  a_trig_follows_match : assert property (@(posedge clk_sys) disable iff (reset)
    match |=> addressMatchPulse)
    else $error("trigger missing after match");

  a_trig_needs_match : assert property (@(posedge clk_sys) disable iff (reset)
    addressMatchPulse |-> $past(match))
    else $error("trigger without match");

  a_halt_on_match : assert property (@(posedge clk_sys) disable iff (reset)
    s_enabledHaltMatch |=> seqFreeze && (st_r.run == MBP_HALTED))
    else $error("halt did not follow match");

  a_jump_on_match : assert property (@(posedge clk_sys) disable iff (reset)
    s_enabledJumpMatch |=> seqLoad && seqFreeze ##1 (st_r.run == MBP_RUN))
    else $error("jump with one-cycle freeze missing");

  a_inhibit_no_action : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_RUN) && !st_r.sw2.cmpEnable && !jumpPress |=> !seqLoad && (st_r.run == MBP_RUN))
    else $error("inhibited compare acted");

  a_halt_holds : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_HALTED) && !restartPress |=> (st_r.run == MBP_HALTED))
    else $error("halt left without restart");

  a_restart_resumes : assert property (@(posedge clk_sys) disable iff (reset)
    restartPress && !specialFreeze |=> !st_r.specFrz && (st_r.run != MBP_HALTED))
    else $error("restart did not resume");

  a_manual_jump_addr : assert property (@(posedge clk_sys) disable iff (reset)
    jumpPress && !restartPress && (st_r.run != MBP_JFRZ) |=> seqLoad && (seqLoadAddr == $past(jumpTarget)))
    else $error("manual jump address wrong");

  a_freeze_lamp : assert property (@(posedge clk_sys) disable iff (reset)
    match |=> freezeLamp)
    else $error("freeze lamp not lit on match");

  sequence s_haltedJump;
    (st_r.run == MBP_HALTED) && jumpPress && !restartPress;
  endsequence

  a_no_trig_idle : assert property (@(posedge clk_sys) disable iff (reset)
    !match |=> !addressMatchPulse)
    else $error("trigger without a matching cycle");

  a_jfrz_one_cycle : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_JFRZ) |=> (st_r.run == MBP_RUN))
    else $error("jump freeze lasted more than one cycle");

  a_manual_jump_frz : assert property (@(posedge clk_sys) disable iff (reset)
    jumpPress && (st_r.run == MBP_RUN) |=> (st_r.run == MBP_JFRZ) && seqFreeze)
    else $error("manual jump without freeze");

  a_halted_jump : assert property (@(posedge clk_sys) disable iff (reset)
    s_haltedJump |=> seqLoad && seqFreeze && (st_r.run == MBP_HALTED))
    else $error("jump in halt did not load or left halt");

  a_restart_wins : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_HALTED) && restartPress |=> (st_r.run == MBP_RUN) && !seqLoad)
    else $error("restart did not leave halt");

  a_halt_no_load : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_HALTED) && !jumpPress |=> !seqLoad)
    else $error("load while halted without jump");

  a_special_set : assert property (@(posedge clk_sys) disable iff (reset)
    specialFreeze |=> seqFreeze && st_r.specFrz)
    else $error("special freeze not taken");

  a_special_holds : assert property (@(posedge clk_sys) disable iff (reset)
    st_r.specFrz && !restartPress |=> st_r.specFrz)
    else $error("special freeze dropped without restart");

  a_load_single : assert property (@(posedge clk_sys) disable iff (reset)
    seqLoad |=> !seqLoad)
    else $error("load lasted more than one cycle");

  a_target_aligned : assert property (@(posedge clk_sys) disable iff (reset)
    seqLoad |-> (seqLoadAddr == $past(jumpTarget)) && (seqLoadAddr[JUMP_LSB-1:0] == '0))
    else $error("load address not the jump target");

  a_freeze_halted : assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.run == MBP_HALTED) |-> freezeLamp)
    else $error("freeze lamp dark during halt");

  // Lamp rows mirror their sources one edge late; these guard the wiring of each field.
  a_store_rank2 : assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (storeLamps[RANK2_HI:RANK2_LO] == $past(secondRankOut[RANK2_HI:RANK2_LO])))
    else $error("second rank lamps wrong");

  a_store_rank1 : assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (storeLamps[RANK1_LO_HI:0] == $past(firstRankOut[RANK1_LO_HI:0]))
      && (storeLamps[LAMP_W-1:RANK1_HI_LO] == $past(firstRankOut[LAMP_W-1:RANK1_HI_LO])))
    else $error("first rank lamps wrong");

  a_bank_lamps : assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (bankLamps == $past(bankBits)))
    else $error("bank lamps wrong");

  a_addr_lamps : assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> (addrLamps == $past(microAddr[AW-1:JUMP_LSB])))
    else $error("microaddress lamps wrong");

  a_bank_select : assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |-> ##2 (bankSelect == $past(bankSw, 2)))
    else $error("bank select does not follow switches");

  a_disp_bus : assert property (@(posedge clk_sys) disable iff (reset)
    st_r.sw2.dispSelBus |=> (regDispLamps == $past(resultBus)))
    else $error("bus display wrong");

  a_disp_reg : assert property (@(posedge clk_sys) disable iff (reset)
    !st_r.sw2.dispSelBus |=> (regDispLamps == $past(selRegValue)))
    else $error("register display wrong");

endmodule

// ==== bench/mbp_seq_model.sv ====
// Purpose: Behavioural microsequencer facing the panel.
// Assumes: The address steps by one each cycle unless frozen.
// Notes:   A load wins over a freeze, as a real sequencer would.
`timescale 1ns/1ps
module mbp_seq_model
  import mbp_pkg::*;
(
  input  wire logic              clk_sys,     // Processor clock.
  input  wire logic              reset,       // Synchronous reset.
  input  wire logic              seqFreeze,   // Hold the address.
  input  wire logic              seqLoad,     // Load a new address.
  input  wire logic [ADDR_W-1:0] seqLoadAddr, // Address to load.
  output logic      [ADDR_W-1:0] microAddr    // Microaddress bus.
);
  always_ff @(posedge clk_sys) begin
    if (reset)
      microAddr <= 16'h0000;
    else if (seqLoad)
      microAddr <= seqLoadAddr;
    else if (!seqFreeze)
      microAddr <= microAddr + 16'h0001;
  end
endmodule

// ==== bench/mbp_panel_tb.sv ====
// Purpose: Self-checking bench for the breakpoint panel.
// Assumes: Switches and buttons change 1 ns after a rising edge.
// Notes:   The operator jumps by hand only while halted.
`timescale 1ns/1ps
module mbp_panel_tb;
  import mbp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] microAddr, cmpSw = 16'h0040, jmpSw = 16'h0204, selReg = 16'h5a5a, resBus = 16'hc3c3;
  logic [31:0] rank1 = 32'h89ab_cdef, rank2 = 32'h1357_9bdf, storeLamps;
  logic [1:0] bankBits = 2'b10, bankSw = 2'b01, bankLamps, bankSelect;
  logic spFrz = 1'b0, cmpEn = 1'b0, haltSel = 1'b0, dispBus = 1'b0, jmpBtn = 1'b0, rstBtn = 1'b0;
  logic [15:2] addrLamps;
  logic [15:0] regDispLamps, seqLoadAddr, lastLoad;
  logic freezeLamp, addressMatchPulse, seqFreeze, seqLoad;
  int n_errors = 0, num_checks = 0, nMatch = 0, nLoad = 0, m0, l0, i;

  mbp_panel u_dut (.clk_sys(clk_sys), .reset(reset), .microAddr(microAddr), .firstRankOut(rank1),
    .secondRankOut(rank2), .bankBits(bankBits), .specialFreeze(spFrz), .selRegValue(selReg),
    .resultBus(resBus), .compareSw(cmpSw), .jumpSw(jmpSw), .cmpEnableSw(cmpEn), .haltSelSw(haltSel),
    .bankSw(bankSw), .dispBusSw(dispBus), .jumpButton(jmpBtn), .restartButton(rstBtn),
    .storeLamps(storeLamps), .bankLamps(bankLamps), .addrLamps(addrLamps), .regDispLamps(regDispLamps),
    .freezeLamp(freezeLamp), .addressMatchPulse(addressMatchPulse), .bankSelect(bankSelect),
    .seqFreeze(seqFreeze), .seqLoad(seqLoad), .seqLoadAddr(seqLoadAddr));
  mbp_seq_model u_seq (.clk_sys(clk_sys), .reset(reset), .seqFreeze(seqFreeze), .seqLoad(seqLoad),
    .seqLoadAddr(seqLoadAddr), .microAddr(microAddr));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    nMatch += (addressMatchPulse === 1'b1);
    if (seqLoad === 1'b1) begin
      nLoad++;
      lastLoad = seqLoadAddr;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic press(input bit jump);
    if (jump)
      jmpBtn = 1'b1;
    else
      rstBtn = 1'b1;
    cyc(10);
    jmpBtn = 1'b0;
    rstBtn = 1'b0;
    cyc(5);
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #40000;
    n_errors++;
    end_sim();
  end

  initial begin
    cyc(3);
    reset = 1'b0;
    cyc(4);
    chk(storeLamps, {rank1[31:28], rank2[27:5], rank1[4:0]});
    chk(bankLamps, 2'b10);
    chk(bankSelect, 2'b01);
    chk(regDispLamps, 16'h5a5a);
    dispBus = 1'b1;
    cyc(4);
    chk(regDispLamps, 16'hc3c3);
    m0 = nMatch;
    cyc(100);
    chk(nMatch - m0, 1);
    chk(seqFreeze, 1'b0);
    chk(nLoad, 0);
    chk(microAddr, 16'h006c);
    cmpSw = 16'h0090;
    cmpEn = 1'b1;
    haltSel = 1'b1;
    for (i = 0; i < 200 && seqFreeze !== 1'b1; i++) cyc(1);
    cyc(20);
    chk(seqFreeze, 1'b1);
    chk(microAddr, 16'h0091);
    chk(addrLamps, 14'h0024);
    chk(freezeLamp, 1'b1);
    l0 = nLoad;
    press(1'b1);
    chk(nLoad - l0, 1);
    chk(lastLoad, 16'h0204);
    chk(seqFreeze, 1'b1);
    press(1'b0);
    chk(seqFreeze, 1'b0);
    cmpSw = 16'h0220;
    jmpSw = 16'h0123;
    haltSel = 1'b0;
    m0 = nMatch;
    for (i = 0; i < 200 && seqLoad !== 1'b1; i++) cyc(1);
    chk(seqLoadAddr, 16'h0120);
    chk(seqFreeze, 1'b1);
    cmpEn = 1'b0;
    cyc(1);
    chk(nMatch - m0, 1);
    chk(seqFreeze, 1'b0);
    chk(microAddr, 16'h0120);
    spFrz = 1'b1;
    cyc(1);
    spFrz = 1'b0;
    cyc(3);
    chk(seqFreeze, 1'b1);
    press(1'b0);
    chk(seqFreeze, 1'b0);
    end_sim();
  end
endmodule
